/* utrx_core.sv */
// Full-duplex UART transmitter and receiver with an APB register slave
//
// The implementer's own choices: register access over APB and the address map.
`include "utrx_defines.svh"

// What this block does
// - Serial output idles high once unit power is set.
// - With power and transmit enable set, a buffer write starts a frame.
// - Start, parity and stop bits are appended by hardware.
// - Buffer moves into the shift register, then bits shift out on serial output.
// - Transmit-done pulses right after the final stop bit, one or two stops.
// - With nothing pending, transmitter idles until the next buffer write.
// - Buffer accepts a new byte once shifting has begun; the next frame starts after one extra clock of stop level.
// - Transmit status bit 1 is buffer full; 1 forbids writing.
// - Transmit status bit 0 is shift busy; 1 means frame in progress.
// - Continuous sending steps full/busy through 10, 01, 11.
// - Receiver samples only while power and receive enable are both set.
// - Falling edge starts counter; after divisor count, low line confirms start.
// - Bits shift in at baud rate; on stop, buffer loads unless overrun; done pulses, or error pulses instead on a flagged frame with merge clear.
// - On overrun the receive buffer keeps its old content.
// - Parity mismatch does not abort; error signalled at frame end.
// - Receiver checks one stop bit and ignores any second one.
// - Reading error status clears its flags.
// - Framing error flag sets when the stop bit is not high.
// - Frame is start, 7 or 8 data, optional parity, 1 or 2 stops.
// - Even parity makes ones even; odd total count of ones flags error.
module utrx_core
   import utrx_pkg::*;
#(
   parameter logic [7:0] DIV_RESET = `UTRX_DIV_RST
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_in,
   output logic serial_out,
   output logic tx_done_irq,
   output logic rx_done_irq,
   output logic rx_error_irq
);
   utrx_state_t s_reg;
   utrx_state_t s_next;

   logic power;
   logic txe;
   logic rxe;
   logic len8;
   logic [1:0] par;
   logic [8:0] period;
   logic setup;
   logic access;
   logic [11:0] frame;
   logic [3:0] tx_total;
   logic [3:0] rx_last;
   logic [7:0] rx_data;
   logic rx_parbit;
   logic rx_stopbit;
   logic pe;
   logic fe;
   logic ove;
   logic [3:0] len;

   assign power = s_reg.mode[`UTRX_MODE_POWER];
   assign txe = power & s_reg.mode[`UTRX_MODE_TXE];
   assign rxe = power & s_reg.mode[`UTRX_MODE_RXE];
   assign len8 = s_reg.mode[`UTRX_MODE_LEN8];
   assign par = s_reg.mode[`UTRX_MODE_PAR_HI:`UTRX_MODE_PAR_LO];
   assign len = len8 ? 4'h8 : 4'h7;
   // Bit period is twice the divisor; a zero divisor acts as one to keep counters sane
   assign period = (s_reg.div == 8'h00) ? 9'h002 : {s_reg.div, 1'b0};
   assign setup = psel & ~penable;
   assign access = psel & penable & s_reg.pready;

   // ----------------------------------------
   // Frame assembly and received frame decode
   // ----------------------------------------
   always_comb begin
      frame = `UTRX_FRAME_IDLE;
      frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < len) begin
            frame[i + 1] = s_reg.txb[i];
         end
      end
      if (par != `UTRX_PAR_NONE) begin
         case (par)
            `UTRX_PAR_ZERO: frame[len + 4'h1] = 1'b0;
            `UTRX_PAR_ODD: frame[len + 4'h1] = ~(^(s_reg.txb & (len8 ? 8'hFF : 8'h7F)));
            default: frame[len + 4'h1] = ^(s_reg.txb & (len8 ? 8'hFF : 8'h7F));
         endcase
      end
      tx_total = 4'h1 + len + ((par != `UTRX_PAR_NONE) ? 4'h1 : 4'h0)
                 + (s_reg.mode[`UTRX_MODE_STOP2] ? 4'h2 : 4'h1);
   end

   always_comb begin
      rx_last = len + ((par != `UTRX_PAR_NONE) ? 4'h1 : 4'h0);
      rx_data = s_reg.rxs[7:0] & (len8 ? 8'hFF : 8'h7F);
      rx_parbit = s_reg.rxs[len];
      rx_stopbit = serial_in;
      pe = 1'b0;
      case (par)
         `UTRX_PAR_EVEN: pe = ^rx_data ^ rx_parbit;
         `UTRX_PAR_ODD: pe = ~(^rx_data ^ rx_parbit);
         default: pe = 1'b0;
      endcase
      fe = ~rx_stopbit;
      ove = s_reg.rx_full;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.tx_done = 1'b0;
      s_next.rx_done = 1'b0;
      s_next.rx_err = 1'b0;
      s_next.rx_prev = serial_in;

      // APB slave: answer is prepared in the setup cycle, so the access phase has no wait
      s_next.pready = setup;
      // Error flag is a pulse with ready, so a stale error never qualifies a later transfer
      s_next.pslverr = 1'b0;
      if (setup) begin
         s_next.pslverr = 1'b0;
         s_next.prdata = 32'h0000_0000;
         case (paddr)
            `UTRX_OFS_MODE: s_next.prdata[7:0] = s_reg.mode;
            `UTRX_OFS_RXERR: s_next.prdata[2:0] = s_reg.err;
            `UTRX_OFS_TXSTAT: s_next.prdata[1:0] = {s_reg.tx_full, s_reg.tx_busy};
            `UTRX_OFS_DIV: s_next.prdata[7:0] = s_reg.div;
            `UTRX_OFS_RXBUF: s_next.prdata[7:0] = s_reg.rxb;
            `UTRX_OFS_TXBUF: s_next.prdata = 32'h0000_0000;
            default: s_next.pslverr = 1'b1;
         endcase
      end
      if (access && pwrite) begin
         case (paddr)
            `UTRX_OFS_MODE: s_next.mode = pwdata[7:0];
            `UTRX_OFS_DIV: s_next.div = pwdata[7:0];
            `UTRX_OFS_TXBUF: begin
               // A write while full is refused; software must poll the full flag first
               if (txe && !s_reg.tx_full) begin
                  s_next.txb = pwdata[7:0];
                  s_next.tx_full = 1'b1;
               end
            end
            default: s_next.mode = s_next.mode;
         endcase
      end
      if (access && !pwrite) begin
         // Only reported bits are cleared, so a flag set after the setup cycle survives
         if (paddr == `UTRX_OFS_RXERR) begin
            s_next.err = s_reg.err & ~s_reg.prdata[2:0];
         end
         if (paddr == `UTRX_OFS_RXBUF) begin
            s_next.rx_full = 1'b0;
         end
      end

      // Transmitter
      case (s_reg.tx_st)
         UTRX_BITS: begin
            if (s_reg.tx_cnt == 9'h000) begin
               if (s_reg.tx_left == 4'h1) begin
                  // Stop level is held one extra clock before a pending byte loads
                  s_next.tx_done = 1'b1;
                  s_next.tx_busy = 1'b0;
                  s_next.tx_st = UTRX_IDLE;
                  s_next.txd = 1'b1;
               end else begin
                  s_next.tx_frame = {1'b1, s_reg.tx_frame[11:1]};
                  s_next.txd = s_reg.tx_frame[1];
                  s_next.tx_left = s_reg.tx_left - 4'h1;
                  s_next.tx_cnt = period - 9'h001;
               end
            end else begin
               s_next.tx_cnt = s_reg.tx_cnt - 9'h001;
            end
         end
         default: begin
            s_next.tx_st = UTRX_IDLE;
            s_next.txd = 1'b1;
            if (s_reg.tx_full) begin
               // The buffer frees as shifting begins, so the next byte may be written at once
               s_next.tx_frame = frame;
               s_next.txd = frame[0];
               s_next.tx_left = tx_total;
               s_next.tx_cnt = period - 9'h001;
               s_next.tx_full = 1'b0;
               s_next.tx_busy = 1'b1;
               s_next.tx_st = UTRX_BITS;
            end
         end
      endcase

      // Receiver
      case (s_reg.rx_st)
         UTRX_START: begin
            if (s_reg.rx_cnt == 9'h000) begin
               if (!serial_in) begin
                  s_next.rx_st = UTRX_BITS;
                  s_next.rx_idx = 4'h0;
                  s_next.rx_cnt = period - 9'h001;
               end else begin
                  s_next.rx_st = UTRX_IDLE;
               end
            end else begin
               s_next.rx_cnt = s_reg.rx_cnt - 9'h001;
            end
         end
         UTRX_BITS: begin
            if (s_reg.rx_cnt == 9'h000) begin
               s_next.rx_cnt = period - 9'h001;
               if (s_reg.rx_idx == rx_last) begin
                  s_next.rx_st = UTRX_IDLE;
                  s_next.err = s_next.err | {pe, fe, ove};
                  if (!ove) begin
                     s_next.rxb = rx_data;
                     s_next.rx_full = 1'b1;
                  end
                  if ((pe | fe | ove) && !s_reg.mode[`UTRX_MODE_MERGE]) begin
                     s_next.rx_err = 1'b1;
                  end else begin
                     s_next.rx_done = 1'b1;
                  end
               end else begin
                  s_next.rxs[s_reg.rx_idx] = serial_in;
                  s_next.rx_idx = s_reg.rx_idx + 4'h1;
               end
            end else begin
               s_next.rx_cnt = s_reg.rx_cnt - 9'h001;
            end
         end
         default: begin
            s_next.rx_st = UTRX_IDLE;
            if (s_reg.rx_prev && !serial_in) begin
               s_next.rx_st = UTRX_START;
               // Half-period resample puts every later sample near mid-bit
               s_next.rx_cnt = ((s_reg.div == 8'h00) ? 9'h001 : {1'b0, s_reg.div}) - 9'h001;
            end
         end
      endcase

      // Enables: each half is held idle on its own; power off also clears status and buffer
      if (!txe) begin
         s_next.tx_st = UTRX_IDLE;
         s_next.tx_full = 1'b0;
         s_next.tx_busy = 1'b0;
         s_next.txd = 1'b1;
      end
      if (!rxe) begin
         s_next.rx_st = UTRX_IDLE;
         // Edge detector rests high, so enabling on an idle line never sees a false start
         s_next.rx_prev = 1'b1;
      end
      if (!power) begin
         s_next.err = 3'h0;
         s_next.rxb = `UTRX_RXBUF_RST;
         s_next.rx_full = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.mode <= `UTRX_MODE_RST;
         s_reg.div <= DIV_RESET;
         s_reg.tx_frame <= `UTRX_FRAME_IDLE;
         s_reg.txd <= 1'b1;
         s_reg.rxb <= `UTRX_RXBUF_RST;
         s_reg.rx_prev <= 1'b1;
         s_reg.tx_st <= UTRX_IDLE;
         s_reg.rx_st <= UTRX_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign serial_out = s_reg.txd;
   assign tx_done_irq = s_reg.tx_done;
   assign rx_done_irq = s_reg.rx_done;
   assign rx_error_irq = s_reg.rx_err;
endmodule

/* utrx_defines.svh */
// Register offsets, field positions, encodings and reset values of the UART core
`ifndef UTRX_DEFINES_SVH
`define UTRX_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UTRX_OFS_MODE 12'h000
`define UTRX_OFS_RXERR 12'h004
`define UTRX_OFS_TXSTAT 12'h008
`define UTRX_OFS_DIV 12'h00C
`define UTRX_OFS_TXBUF 12'h010
`define UTRX_OFS_RXBUF 12'h014
// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define UTRX_MODE_POWER 7
`define UTRX_MODE_TXE 6
`define UTRX_MODE_RXE 5
`define UTRX_MODE_PAR_HI 4
`define UTRX_MODE_PAR_LO 3
`define UTRX_MODE_LEN8 2
`define UTRX_MODE_STOP2 1
`define UTRX_MODE_MERGE 0
`define UTRX_PAR_NONE 2'h0
`define UTRX_PAR_ZERO 2'h1
`define UTRX_PAR_ODD 2'h2
`define UTRX_PAR_EVEN 2'h3
// ----------------------------------------
// Status fields and reset values
// ----------------------------------------
`define UTRX_ERR_PAR 2
`define UTRX_ERR_FRM 1
`define UTRX_ERR_OVR 0
`define UTRX_TXS_FULL 1
`define UTRX_TXS_BUSY 0
`define UTRX_MODE_RST 8'h00
`define UTRX_DIV_RST 8'h10
`define UTRX_RXBUF_RST 8'hFF
`define UTRX_FRAME_IDLE 12'hFFF
`endif

/* utrx_pkg.sv */
// Types shared by the UART core
package utrx_pkg;
   typedef enum logic [1:0] {UTRX_IDLE, UTRX_START, UTRX_BITS} utrx_phase_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] div;
      logic [7:0] txb;
      logic tx_full;
      logic tx_busy;
      utrx_phase_t tx_st;
      logic [11:0] tx_frame;
      logic [3:0] tx_left;
      logic [8:0] tx_cnt;
      logic txd;
      logic tx_done;
      utrx_phase_t rx_st;
      logic [8:0] rx_cnt;
      logic [3:0] rx_idx;
      logic [10:0] rxs;
      logic [7:0] rxb;
      logic rx_full;
      logic [2:0] err;
      logic rx_prev;
      logic rx_done;
      logic rx_err;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } utrx_state_t;
endpackage

/* utrx_chk.sv */
// Port checker for the UART core
`include "utrx_defines.svh"
module utrx_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_out,
   input wire logic tx_done_irq,
   input wire logic rx_done_irq,
   input wire logic rx_error_irq
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   a_apb_answer: assert property (s_setup ##1 s_access |-> pready) else $error("no answer");
   a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_stat_bits: assert property (pready && !pwrite && paddr == `UTRX_OFS_TXSTAT |-> prdata[31:2] == 30'h0)
      else $error("status upper bits");
   a_start_low: assert property ($fell(serial_out) |=> !serial_out) else $error("short start");
   a_done_pulse: assert property (tx_done_irq |=> !tx_done_irq) else $error("done too long");
   a_done_idle: assert property (tx_done_irq |-> serial_out) else $error("done before stop");
   a_rx_pulse: assert property (rx_done_irq |=> !rx_done_irq) else $error("rx done too long");
   a_err_pulse: assert property (rx_error_irq |=> !rx_error_irq) else $error("error too long");
endmodule
bind utrx_core utrx_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_out(serial_out), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));

/* utrx_peer.sv */
// Remote serial node facing the UART core
module utrx_peer #(
   parameter int BIT = 4
) (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out,
   output logic got,
   output logic [8:0] word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] sh;
   initial begin
      line_out = 1'b1;
      got = 1'b0;
      word = 9'h000;
   end
   // -------------
   // Sender
   // -------------
   task automatic send(input logic [7:0] d, input logic pbad, input logic stop);
      logic [10:0] f;
      f = {stop, ^d ^ pbad, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         line_out <= f[i];
         repeat (BIT - 1) @(posedge clk);
      end
      @(posedge clk);
      line_out <= 1'b1;
   endtask
   // -------------
   // Receiver
   // -------------
   // Mid-bit sampling; hands the nine bits after start to the bench
   always begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(posedge clk);
         sh[i] = line_in;
      end
      word <= sh;
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
   end
endmodule

/* tb.sv */
// Self-checking bench for the UART core
`include "utrx_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, watch = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, serial_in, serial_out, tx_done_irq, rx_done_irq, rx_error_irq, got;
   logic [8:0] word;
   logic rx_seen_err = 1'b0;
   logic [32:0] rq[$];
   logic [32:0] sq[$];
   int bad_count = 0, n_tests = 0, seed = 82;
   always #2 pclk = ~pclk;
   utrx_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
      .serial_out(serial_out), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
   // Divisor 2 gives four clocks a bit
   utrx_peer #(.BIT(4)) peer_u (.clk(pclk), .line_in(serial_out), .line_out(serial_in), .got(got), .word(word));
   // ---------
   // Tasks
   // ---------
   task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic hang(input int n, input int lim);
      if (n >= lim) begin
         bad_count++;
         give_verdict;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic c,
         input logic [32:0] e, output logic [31:0] r);
      int n;
      n = 0;
      if (c)
         rq.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      watch <= c;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      hang(n, 50);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      watch <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, 1'b0, 33'h0, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      logic [31:0] r;
      apb(1'b0, a, 8'h00, 1'b1, e, r);
   endtask
   task automatic wait_irq(input logic rx);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((rx ? rx_done_irq | rx_error_irq : tx_done_irq) !== 1'b1 && n < 3000);
      rx_seen_err = rx_error_irq;
      hang(n, 3000);
   endtask
   // Results are matched oldest first against the notes
   always @(posedge pclk) begin
      if (pready === 1'b1 && watch && !pwrite)
         cmp("read", rq.pop_front(), {pslverr, prdata});
      if (got === 1'b1)
         cmp("serial", sq.pop_front(), {24'h0, word});
   end
   // ---------
   // Sequence
   // ---------
   initial begin
      logic [31:0] r;
      logic [7:0] b, eb;
      logic [32:0] ev[5];
      int n;
      ev = '{33'h0, 33'h4, 33'h2, 33'h0, 33'h1};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`UTRX_OFS_MODE, 33'h0);
      rd(`UTRX_OFS_DIV, 33'h10);
      rd(`UTRX_OFS_RXBUF, 33'hFF);
      rd(12'h018, 33'h1_0000_0000);
      wr(`UTRX_OFS_TXSTAT, 8'h03);
      rd(`UTRX_OFS_TXSTAT, 33'h0);
      $display("register test done");
      wr(`UTRX_OFS_MODE, 8'h80);
      cmp("line", 33'h1, {32'h0, serial_out});
      wr(`UTRX_OFS_TXBUF, 8'h5A);
      rd(`UTRX_OFS_TXSTAT, 33'h0);
      wr(`UTRX_OFS_DIV, 8'h02);
      for (int p = 0; p < 4; p++) begin
         wr(`UTRX_OFS_MODE, 8'hE4 | 8'(p << 3) | (p == 3 ? 8'h02 : 8'h00));
         for (int k = 0; k < 2; k++) begin
            b = 8'($random(seed));
            sq.push_back({24'h0, p == 0 ? 1'b1 : p == 1 ? 1'b0 : ^b ^ (p == 2), b});
            n = 0;
            do begin
               apb(1'b0, `UTRX_OFS_TXSTAT, 8'h00, 1'b0, 33'h0, r);
               n++;
            end while (r[1] !== 1'b0 && n < 100);
            hang(n, 100);
            wr(`UTRX_OFS_TXBUF, b);
         end
         rd(`UTRX_OFS_TXSTAT, 33'h3);
         wait_irq(1'b0);
         wait_irq(1'b0);
         rd(`UTRX_OFS_TXSTAT, 33'h0);
      end
      $display("transmit test done");
      // Two stops still configured: frames follow after one stop
      for (int k = 0; k < 5; k++) begin
         b = 8'($random(seed));
         fork
            peer_u.send(b, k == 1, k != 2);
            wait_irq(1'b1);
         join
         cmp("error irq", {32'h0, ev[k] != 33'h0}, {32'h0, rx_seen_err});
         if (k != 4)
            eb = b;
         if (k != 3) begin
            rd(`UTRX_OFS_RXERR, ev[k]);
            rd(`UTRX_OFS_RXBUF, {25'h0, eb});
         end
      end
      rd(`UTRX_OFS_RXERR, 33'h0);
      wr(`UTRX_OFS_MODE, 8'hDE);
      peer_u.send(8'h3C, 1'b0, 1'b1);
      rd(`UTRX_OFS_RXBUF, {25'h0, eb});
      $display("receive test done");
      give_verdict;
   end
endmodule
